// [shared/avcalc_cfg.svh]
`ifndef AVCALC_CFG_SVH
`define AVCALC_CFG_SVH

// ----------------------------------------------------------------
// Frame addresses, instruction codes and reply status.
// ----------------------------------------------------------------
`define AVC_DEV_ADDR       8'h01
`define AVC_HOST_ADDR      8'h02
`define AVC_INSTR_ACC_TGT  8'h2A
`define AVC_INSTR_VAR_TGT  8'h2B
`define AVC_STATUS_OK      8'h64
`define AVC_RESET_WORD     32'h0000_0000

// ----------------------------------------------------------------
// Frame byte positions, counted from zero.
// ----------------------------------------------------------------
`define AVC_POS_ADDR       4'h0
`define AVC_POS_INSTR      4'h1
`define AVC_POS_TYPE       4'h2
`define AVC_POS_INDEX      4'h3
`define AVC_POS_CHECK      4'h8

// ----------------------------------------------------------------
// Operation codes carried in the type byte.
// ----------------------------------------------------------------
`define AVC_OP_ADD         4'h0
`define AVC_OP_SUB         4'h1
`define AVC_OP_MUL         4'h2
`define AVC_OP_DIV         4'h3
`define AVC_OP_REM         4'h4
`define AVC_OP_AND         4'h5
`define AVC_OP_OR          4'h6
`define AVC_OP_XOR         4'h7
`define AVC_OP_NOT         4'h8
`define AVC_OP_LOAD        4'h9
`define AVC_OP_SWAP        4'hA
`define AVC_OP_COMP        4'hB

// ----------------------------------------------------------------
// Divider step count: one quotient bit per clock.
// ----------------------------------------------------------------
`define AVC_DIV_LAST       5'h1F

`endif

// [shared/avcalc_pkg.sv]
package avcalc_pkg;

  // Signed data word of the accumulator, X register and variables.
  typedef logic [31:0] avc_word_t;

  // Sequencer states of the calculation core.
  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_divw,
    st_reply
  } avc_state_t;

endpackage

// [rtl/avcalc_div.sv]
`timescale 1ns/10ps
`include "avcalc_cfg.svh"

module avcalc_div (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  start_in,
  input  wire avcalc_pkg::avc_word_t dividend_in,
  input  wire avcalc_pkg::avc_word_t divisor_in,
  output logic                       done_out,
  output avcalc_pkg::avc_word_t      quot_out,
  output avcalc_pkg::avc_word_t      rem_out
);

  logic [31:0] rem_q;
  logic [31:0] quo_q;
  logic [31:0] dvs_q;
  logic [4:0]  cnt_q;
  logic        busy_q;
  logic        qneg_q;
  logic        rneg_q;
  logic [32:0] shl;
  logic [32:0] dif;
  logic [31:0] rem_n;
  logic [31:0] quo_n;

  // ----------------------------------------------------------------
  // Restoring step on magnitudes; signs are applied at the end so the
  // quotient truncates toward zero and the remainder follows the dividend.
  // ----------------------------------------------------------------
  assign shl   = {rem_q, quo_q[31]};
  assign dif   = shl - {1'b0, dvs_q};
  assign rem_n = dif[32] ? shl[31:0] : dif[31:0];
  assign quo_n = {quo_q[30:0], ~dif[32]};

  // Iteration registers; a zero divisor is never started by the core.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rem_q  <= 32'h0;
      quo_q  <= 32'h0;
      dvs_q  <= 32'h0;
      cnt_q  <= 5'h0;
      busy_q <= 1'b0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
    end else if (start_in) begin
      rem_q  <= 32'h0;
      quo_q  <= dividend_in[31] ? 32'h0 - dividend_in : dividend_in;
      dvs_q  <= divisor_in[31] ? 32'h0 - divisor_in : divisor_in;
      cnt_q  <= 5'h0;
      busy_q <= 1'b1;
      qneg_q <= dividend_in[31] ^ divisor_in[31];
      rneg_q <= dividend_in[31];
    end else if (busy_q) begin
      rem_q <= rem_n;
      quo_q <= quo_n;
      cnt_q <= cnt_q + 5'h1;
      if (cnt_q == `AVC_DIV_LAST) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Signed results and the one-cycle completion pulse.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      quot_out <= 32'h0;
      rem_out  <= 32'h0;
    end else begin
      done_out <= busy_q && (cnt_q == `AVC_DIV_LAST);
      if (busy_q && (cnt_q == `AVC_DIV_LAST)) begin
        quot_out <= qneg_q ? 32'h0 - quo_n : quo_n;
        rem_out  <= rneg_q ? 32'h0 - rem_n : rem_n;
      end
    end
  end

  a_div_latency: assert property (@(posedge clk_in) disable iff (rst_in)
    start_in |-> ##[33:34] done_out)
    else $error("Divider did not finish in 33 cycles.");

endmodule // avcalc_div

// [rtl/avcalc_rx.sv]
`timescale 1ns/10ps
`include "avcalc_cfg.svh"

module avcalc_rx (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       byte_valid_in,
  input  wire logic       take_in,
  output logic            ready_out,
  output logic            frame_valid_out,
  output logic [7:0]      instr_out,
  output logic [3:0]      type_out,
  output logic [7:0]      index_out
);

  logic [3:0] cnt_q;
  logic [7:0] sum_q;
  logic [7:0] addr_q;
  logic       accept;
  logic       good;

  // ----------------------------------------------------------------
  // Byte collection. The four value bytes only feed the sum: their
  // contents never reach the calculation.
  // ----------------------------------------------------------------
  assign accept = byte_valid_in && ready_out;
  assign good   = (byte_in == sum_q) && (addr_q == `AVC_DEV_ADDR);

  // Field capture in host order: address, instruction, type, index.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q     <= 4'h0;
      sum_q     <= 8'h0;
      addr_q    <= 8'h0;
      instr_out <= 8'h0;
      type_out  <= 4'h0;
      index_out <= 8'h0;
    end else if (accept) begin
      cnt_q <= (cnt_q == `AVC_POS_CHECK) ? 4'h0 : cnt_q + 4'h1;
      sum_q <= (cnt_q == `AVC_POS_CHECK) ? 8'h0 : sum_q + byte_in;
      if (cnt_q == `AVC_POS_ADDR) begin
        addr_q <= byte_in;
      end
      if (cnt_q == `AVC_POS_INSTR) begin
        instr_out <= byte_in;
      end
      if (cnt_q == `AVC_POS_TYPE) begin
        // Type codes above 15 fold into the reserved code 15.
        type_out <= (byte_in > 8'h0F) ? 4'hF : byte_in[3:0];
      end
      if (cnt_q == `AVC_POS_INDEX) begin
        index_out <= byte_in;
      end
    end
  end

  // A whole frame is held until taken; the host stalls meanwhile.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_valid_out <= 1'b0;
      ready_out       <= 1'b1;
    end else if (accept && (cnt_q == `AVC_POS_CHECK) && good) begin
      frame_valid_out <= 1'b1;
      ready_out       <= 1'b0;
    end else if (take_in) begin
      frame_valid_out <= 1'b0;
      ready_out       <= 1'b1;
    end
  end

  a_bad_sum_drop: assert property (@(posedge clk_in) disable iff (rst_in)
    accept && (cnt_q == `AVC_POS_CHECK) && (byte_in != sum_q)
    && !frame_valid_out |=> !frame_valid_out)
    else $error("Frame with a wrong checksum was accepted.");

endmodule // avcalc_rx

// [rtl/avcalc_core.sv]
`timescale 1ns/10ps
`include "avcalc_cfg.svh"

// ----------------------------------------------------------------
// ----------------------------------------------------------------

module avcalc_core (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic [7:0]            rx_byte_in,
  input  wire logic                  rx_valid_in,
  output logic                       rx_ready_out,
  output logic [7:0]                 tx_byte_out,
  output logic                       tx_valid_out,
  input  wire logic                  tx_ready_in,
  input  wire logic                  acc_load_in,
  input  wire avcalc_pkg::avc_word_t acc_data_in,
  input  wire logic                  x_load_in,
  input  wire avcalc_pkg::avc_word_t x_data_in,
  output avcalc_pkg::avc_word_t      accum_out,
  output avcalc_pkg::avc_word_t      xreg_out,
  output logic                       cmp_lt_out,
  output logic                       cmp_eq_out,
  output logic                       cmp_gt_out,
  output logic                       busy_out
);

  avcalc_pkg::avc_state_t state_q;
  avcalc_pkg::avc_word_t  var_q [256];
  avcalc_pkg::avc_word_t  x_q, val_q, a_val, b_val, alu_res, res_val;
  avcalc_pkg::avc_word_t  var_wdata, quot, rem;
  logic [7:0]             instr_q, idx_q, chk_q, tx_sum_q, chk_d;
  logic [7:0]             next_byte, f_instr, f_index;
  logic [3:0]             op_q, tx_idx_q, f_type;
  logic                   frame_valid, take, is_acc, div_op, div_start;
  logic                   div_done, commit, dest_wr, swap, cmp, var_we;

  // ----------------------------------------------------------------
  // Frame reception and the shared divider.
  // ----------------------------------------------------------------
  avcalc_rx u_rx (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .byte_in         (rx_byte_in),
    .byte_valid_in   (rx_valid_in),
    .take_in         (take),
    .ready_out       (rx_ready_out),
    .frame_valid_out (frame_valid),
    .instr_out       (f_instr),
    .type_out        (f_type),
    .index_out       (f_index)
  );

  avcalc_div u_div (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .start_in    (div_start),
    .dividend_in (a_val),
    .divisor_in  (b_val),
    .done_out    (div_done),
    .quot_out    (quot),
    .rem_out     (rem)
  );

  // ----------------------------------------------------------------
  // Operand selection and arithmetic.
  // ----------------------------------------------------------------

  // A is the destination operand and B the source for both forms.
  assign is_acc = (instr_q == `AVC_INSTR_ACC_TGT);
  assign a_val  = is_acc ? accum_out : var_q[idx_q];
  assign b_val  = is_acc ? var_q[idx_q] : x_q;
  assign div_op = (op_q == `AVC_OP_DIV) || (op_q == `AVC_OP_REM);

  // Single-cycle operations; the product keeps its low 32 bits only.
  always_comb begin
    alu_res = a_val;
    case (op_q)
      `AVC_OP_ADD:  alu_res = a_val + b_val;
      `AVC_OP_SUB:  alu_res = a_val - b_val;
      `AVC_OP_MUL:  alu_res = 32'(a_val * b_val);
      `AVC_OP_AND:  alu_res = a_val & b_val;
      `AVC_OP_OR:   alu_res = a_val | b_val;
      `AVC_OP_XOR:  alu_res = a_val ^ b_val;
      `AVC_OP_NOT:  alu_res = ~b_val;
      `AVC_OP_LOAD: alu_res = b_val;
      default:      alu_res = a_val;
    endcase
  end

  // Divide by zero keeps the destination, so no step can hang.
  assign res_val = !div_op ? alu_res
                 : (b_val == 32'h0) ? a_val
                 : (op_q == `AVC_OP_DIV) ? quot : rem;

  // ----------------------------------------------------------------
  // Sequencing: take a frame, execute, then answer.
  // ----------------------------------------------------------------
  assign take      = (state_q == avcalc_pkg::st_idle) && frame_valid;
  assign div_start = (state_q == avcalc_pkg::st_exec) && div_op
                     && (b_val != 32'h0);
  assign commit    = ((state_q == avcalc_pkg::st_exec) && !div_start)
                     || ((state_q == avcalc_pkg::st_divw) && div_done);
  assign dest_wr   = commit && (op_q <= `AVC_OP_LOAD);
  assign swap      = commit && (op_q == `AVC_OP_SWAP);
  assign cmp       = commit && (op_q == `AVC_OP_COMP);

  // Reply checksum over host, module, status, code and value bytes.
  assign chk_d = `AVC_HOST_ADDR + `AVC_DEV_ADDR + `AVC_STATUS_OK
                 + instr_q + res_val[31:24] + res_val[23:16]
                 + res_val[15:8] + res_val[7:0];

  // Byte that follows the one on the wire now.
  always_comb begin
    next_byte = chk_q;
    case (tx_idx_q)
      4'h0:    next_byte = `AVC_DEV_ADDR;
      4'h1:    next_byte = `AVC_STATUS_OK;
      4'h2:    next_byte = instr_q;
      4'h3:    next_byte = val_q[31:24];
      4'h4:    next_byte = val_q[23:16];
      4'h5:    next_byte = val_q[15:8];
      4'h6:    next_byte = val_q[7:0];
      default: next_byte = chk_q;
    endcase
  end

  // Control state; only codes 42 and 43 with types 0..11 are executed.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= avcalc_pkg::st_idle;
      instr_q <= 8'h0;
      op_q    <= 4'h0;
      idx_q   <= 8'h0;
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state_q != avcalc_pkg::st_idle) || frame_valid;
      case (state_q)
        avcalc_pkg::st_idle: begin
          if (take && (f_type <= `AVC_OP_COMP)
              && ((f_instr == `AVC_INSTR_ACC_TGT)
              || (f_instr == `AVC_INSTR_VAR_TGT))) begin
            state_q <= avcalc_pkg::st_exec;
            instr_q <= f_instr;
            op_q    <= f_type;
            idx_q   <= f_index;
          end
        end
        avcalc_pkg::st_exec: begin
          state_q <= div_start ? avcalc_pkg::st_divw
                               : avcalc_pkg::st_reply;
        end
        avcalc_pkg::st_divw: begin
          if (div_done) begin
            state_q <= avcalc_pkg::st_reply;
          end
        end
        default: begin
          if (tx_ready_in && (tx_idx_q == `AVC_POS_CHECK)) begin
            state_q <= avcalc_pkg::st_idle;
          end
        end
      endcase
    end
  end

  // Reply serialiser; each byte stands until the host takes it.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_valid_out <= 1'b0;
      tx_byte_out  <= 8'h0;
      tx_idx_q     <= 4'h0;
      val_q        <= `AVC_RESET_WORD;
      chk_q        <= 8'h0;
    end else if (commit) begin
      tx_valid_out <= 1'b1;
      tx_byte_out  <= `AVC_HOST_ADDR;
      tx_idx_q     <= 4'h0;
      val_q        <= res_val;
      chk_q        <= chk_d;
    end else if (tx_valid_out && tx_ready_in) begin
      tx_idx_q <= tx_idx_q + 4'h1;
      tx_byte_out <= next_byte;
      if (tx_idx_q == `AVC_POS_CHECK) begin
        tx_valid_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Architectural state.
  // ----------------------------------------------------------------

  // Accumulator; a commit outranks a load from the rest of the device.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      accum_out <= `AVC_RESET_WORD;
    end else if (is_acc && dest_wr) begin
      accum_out <= res_val;
    end else if (is_acc && swap) begin
      accum_out <= b_val;
    end else if (acc_load_in) begin
      accum_out <= acc_data_in;
    end
  end

  // X register is written only by the exchange or by an outside load.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      x_q <= `AVC_RESET_WORD;
    end else if (!is_acc && swap) begin
      x_q <= a_val;
    end else if (x_load_in) begin
      x_q <= x_data_in;
    end
  end

  assign xreg_out = x_q;

  // Variable write port: result, or the register side of an exchange.
  assign var_we    = (!is_acc && dest_wr) || swap;
  assign var_wdata = is_acc ? a_val : (swap ? b_val : res_val);

  // One storage word per variable index.
  for (genvar gi = 0; gi < 256; gi++) begin : g_var
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        var_q[gi] <= `AVC_RESET_WORD;
      end else if (var_we && (idx_q == 8'(gi))) begin
        var_q[gi] <= var_wdata;
      end
    end
  end

  // Compare flags persist for later conditional steps.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_lt_out <= 1'b0;
      cmp_eq_out <= 1'b0;
      cmp_gt_out <= 1'b0;
    end else if (cmp) begin
      cmp_lt_out <= $signed(a_val) < $signed(b_val);
      cmp_eq_out <= a_val == b_val;
      cmp_gt_out <= $signed(a_val) > $signed(b_val);
    end
  end

  // Running sum of sent bytes, an independent view of the checksum.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_sum_q <= 8'h0;
    end else if (commit) begin
      tx_sum_q <= 8'h0;
    end else if (tx_valid_out && tx_ready_in) begin
      tx_sum_q <= tx_sum_q + tx_byte_out;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  sequence s_acc_add;
    commit && is_acc && (op_q == `AVC_OP_ADD);
  endsequence
  sequence s_var_load;
    commit && !is_acc && (op_q == `AVC_OP_LOAD);
  endsequence
  sequence s_reply_open;
    commit ##1 tx_valid_out && (tx_byte_out == `AVC_HOST_ADDR);
  endsequence

  a_acc_add_sum: assert property (@(posedge clk_in) disable iff (rst_in)
    s_acc_add |=> accum_out == $past(a_val) + $past(b_val))
    else $error("Accumulator add gave a wrong sum.");

  a_var_from_x: assert property (@(posedge clk_in) disable iff (rst_in)
    s_var_load |=> var_q[idx_q] == x_q)
    else $error("Variable did not receive X.");

  a_not_inverse: assert property (@(posedge clk_in) disable iff (rst_in)
    commit && is_acc && (op_q == `AVC_OP_NOT)
    |=> accum_out == ~var_q[idx_q])
    else $error("Inverse load gave a wrong value.");

  a_xor_var_x: assert property (@(posedge clk_in) disable iff (rst_in)
    commit && !is_acc && (op_q == `AVC_OP_XOR)
    |=> var_q[idx_q] == ($past(a_val) ^ x_q))
    else $error("Variable XOR with X is wrong.");

  a_swap_exchange: assert property (@(posedge clk_in) disable iff (rst_in)
    swap && is_acc |=> (accum_out == $past(b_val))
    && (var_q[idx_q] == $past(a_val)))
    else $error("Exchange with the accumulator failed.");

  a_cmp_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
    cmp && is_acc && !acc_load_in |=> $stable(accum_out)
    && (cmp_eq_out == (accum_out == var_q[idx_q])))
    else $error("Compare changed an operand or set wrong flags.");

  a_reply_start: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == avcalc_pkg::st_exec) && !div_op
    |-> s_reply_open)
    else $error("Reply did not open with the host address.");

  a_status_ok: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_valid_out && (tx_idx_q == 4'h2)
    |-> tx_byte_out == `AVC_STATUS_OK)
    else $error("Reply status is not 100.");

  a_reply_sum: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_valid_out && (tx_idx_q == `AVC_POS_CHECK)
    |-> tx_byte_out == tx_sum_q)
    else $error("Reply checksum is wrong.");

  a_div_finish: assert property (@(posedge clk_in) disable iff (rst_in)
    div_start |-> ##[33:34] (state_q == avcalc_pkg::st_reply))
    else $error("Division did not complete in time.");

endmodule // avcalc_core

// [bench/avc_host.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Host model: sends command frames and takes reply bytes.
// ----------------------------------------------------------------
module avc_host (
  input  wire logic       clk_in,
  input  wire logic       rx_ready_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_byte_in,
  output logic [7:0]      byte_out,
  output logic            valid_out,
  output logic            ready_out
);
  logic [7:0] rep [9];
  int         hangs = 0;

  // Lines start quiet so the core sees no stray byte.
  initial begin
    byte_out  = 8'h00;
    valid_out = 1'b0;
    ready_out = 1'b0;
  end

  // Index is 8 bits wide and the value field is always zero.
  task automatic send(input logic [7:0] ins, ty, idx,
                      input bit bad);
    logic [7:0] f [9];
    int         k;
    f = '{8'h01, ins, ty, idx, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    if (bad) f[8] = ~f[8];
    for (int i = 0; i < 9; i++) begin
      if (i > 0) #1;
      byte_out  = f[i];
      valid_out = 1'b1;
      k = 0;
      do begin @(posedge clk_in); k++; end while (!rx_ready_in && k < 100);
      if (!rx_ready_in) hangs++;
    end
    #1 valid_out = 1'b0;
    byte_out = ~byte_out; // Released line shows no stale byte.
  endtask

  // A gap above zero makes the host a slow taker of replies.
  task automatic recv(input int gap, output bit got);
    int k;
    got = 0;
    ready_out = 1'b1;
    for (int i = 0; i < 9; i++) begin
      k = 0;
      do begin @(posedge clk_in); k++; end while (!tx_valid_in && k < 80);
      if (!tx_valid_in) begin
        #1 ready_out = 1'b0;
        return;
      end
      rep[i] = tx_byte_in;
      // Ready stays up between bytes unless the host is slow.
      if (gap > 0 || i == 8) #1 ready_out = 1'b0;
      if (i < 8 && gap > 0) begin
        repeat (gap) @(posedge clk_in);
        #1 ready_out = 1'b1;
      end
    end
    got = 1;
  endtask
endmodule // avc_host

// [bench/tb_accum_xreg_var_calc.sv]
`timescale 1ns/10ps

module tb_accum_xreg_var_calc;
  logic                  clk_in, rst_in, rxv, rxr, txv, txr;
  logic                  acc_load, x_load, lt, eq, gt, busy;
  logic [7:0]            rxb, txb;
  avcalc_pkg::avc_word_t acc_data, x_data, accum, xreg, v;
  int                    err_count = 0;
  int                    compares = 0;

  avcalc_core i_avcalc_core (.clk_in(clk_in), .rst_in(rst_in),
    .rx_byte_in(rxb), .rx_valid_in(rxv), .rx_ready_out(rxr),
    .tx_byte_out(txb), .tx_valid_out(txv), .tx_ready_in(txr),
    .acc_load_in(acc_load), .acc_data_in(acc_data), .x_load_in(x_load),
    .x_data_in(x_data), .accum_out(accum), .xreg_out(xreg),
    .cmp_lt_out(lt), .cmp_eq_out(eq), .cmp_gt_out(gt), .busy_out(busy));

  avc_host i_avc_host (.clk_in(clk_in), .rx_ready_in(rxr),
    .tx_valid_in(txv), .tx_byte_in(txb), .byte_out(rxb),
    .valid_out(rxv), .ready_out(txr));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    err_count += i_avc_host.hangs;
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Loads go in only while the core is idle, so no commit can win.
  task automatic load(input logic [31:0] a, x);
    @(posedge clk_in);
    #1 {acc_load, x_load, acc_data, x_data} = {2'b11, a, x};
    @(posedge clk_in);
    #1 {acc_load, x_load} = 2'b00;
  endtask

  // Reference result: signed divide truncates, remainder keeps sign.
  function automatic logic [31:0] calc(int t, logic [31:0] a, b);
    case (t)
      0: return a + b;
      1: return a - b;
      2: return a * b;
      3: return $signed(a) / $signed(b);
      4: return $signed(a) % $signed(b);
      5: return a & b;
      6: return a | b;
      7: return a ^ b;
      8: return ~b;
      default: return b;
    endcase
  endfunction

  task automatic run(input logic [7:0] ins, ty, idx, input int gap);
    bit         got;
    logic [7:0] r [9];
    logic [7:0] s;
    i_avc_host.send(ins, ty, idx, 1'b0);
    i_avc_host.recv(gap, got);
    r = i_avc_host.rep;
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += r[i];
    check(32'(got), 32'h1);
    check({r[0], r[1], r[2], r[3]}, {8'h02, 8'h01, 8'h64, ins});
    check(32'(r[8]), 32'(s));
    v = {r[4], r[5], r[6], r[7]};
    @(posedge clk_in);
    #1 check(32'(busy), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_acc_target;
    load(32'h0000_0064, 32'hFFFF_FFF9);
    run(8'h2B, 8'h09, 8'hFF, 0);
    check(v, 32'hFFFF_FFF9);
    for (int t = 0; t < 10; t++) begin
      load(32'h0000_0064, 32'hFFFF_FFF9);
      run(8'h2A, 8'(t), 8'hFF, 0);
      check(accum, calc(t, 32'h0000_0064, 32'hFFFF_FFF9));
    end
  endtask

  task automatic sc_var_target;
    for (int t = 0; t < 10; t++) begin
      load(32'h0, 32'hFFFF_FF9C);
      run(8'h2B, 8'h09, 8'h00, 0);
      load(32'h0, 32'h0000_0007);
      run(8'h2B, 8'(t), 8'h00, 1);
      check(v, calc(t, 32'hFFFF_FF9C, 32'h0000_0007));
      check(xreg, 32'h0000_0007);
    end
  endtask

  task automatic sc_swap_compare;
    load(32'h5, 32'h9);
    run(8'h2B, 8'h09, 8'h03, 0);
    run(8'h2A, 8'h0B, 8'h03, 0);
    check(accum, 32'h5);
    check({29'h0, lt, eq, gt}, 32'h4);
    run(8'h2A, 8'h0A, 8'h03, 0);
    check(accum, 32'h9);
    load(32'h0, 32'h1);
    run(8'h2B, 8'h0B, 8'h03, 0);
    check(xreg, 32'h1);
    check({29'h0, lt, eq, gt}, 32'h1);
    run(8'h2B, 8'h0A, 8'h03, 0);
    check(xreg, 32'h5);
    run(8'h2A, 8'h09, 8'h03, 2);
    check(accum, 32'h1);
    run(8'h2A, 8'h0B, 8'h03, 0);
    check({29'h0, lt, eq, gt}, 32'h2);
  endtask

  task automatic sc_refused;
    bit got;
    load(32'h4D, 32'h1);
    i_avc_host.send(8'h2A, 8'h00, 8'h03, 1'b1);
    i_avc_host.recv(0, got);
    check(accum, 32'h4D);
    check(32'(got), 32'h0);
    i_avc_host.send(8'h2C, 8'h00, 8'h03, 1'b0);
    i_avc_host.recv(0, got);
    check(accum, 32'h4D);
    check(32'(got), 32'h0);
    i_avc_host.send(8'h2A, 8'h0C, 8'h03, 1'b0);
    i_avc_host.recv(0, got);
    check(accum, 32'h4D);
    check(32'(got), 32'h0);
    run(8'h2A, 8'h00, 8'h03, 3);
    check(accum, 32'h4E);
    run(8'h2A, 8'h03, 8'h10, 0);
    check(accum, 32'h4E);
  endtask

  // Free-running clock, 10 ns period.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Main sequence: reset for three cycles, then the scenarios.
  initial begin
    {rst_in, acc_load, x_load, acc_data, x_data} = {3'b100, 64'h0};
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    sc_acc_target();
    sc_var_target();
    sc_swap_compare();
    sc_refused();
    tally_and_finish();
  end
endmodule // tb_accum_xreg_var_calc
